/* hw/alw_pkg.sv */
package alw_pkg;
    localparam logic [7:0] OP_LOG_WRITE = 8'h3f;
    localparam logic [7:0] OP_BLOCK_WRITE = 8'hc5;
    localparam logic [2:0] TF_FEATURE = 3'h1;
    localparam logic [2:0] TF_SECT_COUNT = 3'h2;
    localparam logic [2:0] TF_SECT_NUM = 3'h3;
    localparam logic [2:0] TF_CYL_LOW = 3'h4;
    localparam logic [2:0] TF_CYL_HIGH = 3'h5;
    localparam logic [2:0] TF_DEV_HEAD = 3'h6;
    localparam logic [2:0] TF_COMMAND = 3'h7;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_UNC = 6;
    localparam int ER_ABT = 2;
    localparam int DH_LBA = 6;
    localparam logic [7:0] DH_FIXED = 8'ha0;
    localparam int SECTOR_BYTES = 512;
    localparam int SECTOR_WORDS = SECTOR_BYTES / 2;
    localparam logic [7:0] LAST_WORD = 8'(SECTOR_WORDS - 1);
    localparam logic [7:0] STATUS_RESET = 8'h50;
    localparam logic [7:0] ERROR_RESET = 8'h00;
endpackage

/* hw/alw_tf_if.sv */
`timescale 1ns/10ps
interface alw_tf_if;
    logic tfWr;
    logic [2:0] tfAddr;
    logic [7:0] tfData;
    logic intAck;
    logic dataValid;
    logic [15:0] dataWord;
    logic dataReady;
    logic intrq;
    logic [7:0] statusFlags;
    logic [7:0] errorFlags;
    logic [7:0] outSectCount;
    logic [7:0] outSectNum;
    logic [7:0] outCylLow;
    logic [7:0] outCylHigh;
    logic [3:0] outHead;
    modport dev (
        input tfWr, tfAddr, tfData, intAck, dataValid, dataWord,
        output dataReady, intrq, statusFlags, errorFlags,
        output outSectCount, outSectNum, outCylLow, outCylHigh, outHead
    );
    modport host (
        output tfWr, tfAddr, tfData, intAck, dataValid, dataWord,
        input dataReady, intrq, statusFlags, errorFlags,
        input outSectCount, outSectNum, outCylLow, outCylHigh, outHead
    );
endinterface

/* hw/alw_device.sv */
`timescale 1ns/10ps
module alw_device #(
    parameter int NUM_LOGS = 4,
    parameter int LOG_SECTORS = 2,
    parameter logic [NUM_LOGS-1:0] READ_ONLY_LOGS = 'h1,
    parameter int SPT = 63,
    parameter int HEADS = 16
) (
    input wire logic clk,
    input wire logic rst,
    alw_tf_if.dev tf,
    input wire logic [NUM_LOGS-1:0] logFeatureEn,
    input wire logic [7:0] multBlock,
    input wire logic mediaErr,
    output logic wrValid,
    output logic [15:0] wrWord,
    output logic [27:0] wrAddr,
    input wire logic wrReady,
    input wire logic [$clog2(NUM_LOGS*LOG_SECTORS*256)-1:0] logRdAddr,
    output logic [15:0] logRdData
);
    localparam int MEM_WORDS = NUM_LOGS * LOG_SECTORS * alw_pkg::SECTOR_WORDS;
    localparam int MW = $clog2(MEM_WORDS);
    localparam int LSW = NUM_LOGS > 1 ? $clog2(NUM_LOGS) : 1;
    typedef enum logic [1:0] {S_IDLE, S_CHECK, S_XFER, S_DRAIN} alw_state_t;

    alw_state_t state_ff, nxt_state;
    logic [7:0] scCur_ff, scPrev_ff, sn_ff, clCur_ff, clPrev_ff, ch_ff, dh_ff, cmd_ff;
    logic isLog_ff, abort, finish, blockEnd;
    logic [16:0] secLeft_ff, blkLeft_ff, nxt_blkLeft;
    logic [7:0] wordInSec_ff;
    logic [27:0] curAddr_ff, lastAddr_ff;
    logic [MW-1:0] memPtr_ff;
    logic [15:0] logMem [MEM_WORDS];
    logic [15:0] fifo_ff [2];
    logic wPtr_ff, rPtr_ff;
    logic [1:0] cnt_ff, nxt_cnt;
    logic accept, pop, flush, sinkFree;
    logic rdy_ff, intrq_ff;
    logic [7:0] status_ff, error_ff, nxt_error;
    logic [7:0] oSc_ff, oSn_ff, oCl_ff, oCh_ff;
    logic [3:0] oHead_ff;
    logic [16:0] logCount, logStart, logEnd;
    logic [7:0] logSel;
    logic logBad;
    logic [16:0] multCount, blkSecs;

    assign tf.dataReady = rdy_ff;
    assign tf.intrq = intrq_ff;
    assign tf.statusFlags = status_ff;
    assign tf.errorFlags = error_ff;
    assign tf.outSectCount = oSc_ff;
    assign tf.outSectNum = oSn_ff;
    assign tf.outCylLow = oCl_ff;
    assign tf.outCylHigh = oCh_ff;
    assign tf.outHead = oHead_ff;

    function automatic logic [27:0] alw_next_addr(input logic [27:0] a, input logic lba);
        logic [27:0] r;
        r = a;
        if (lba)
            r = a + 28'h1;
        else if (a[7:0] == 8'(SPT))
        begin
            r[7:0] = 8'h1;
            if (a[27:24] == 4'(HEADS - 1))
            begin
                r[27:24] = 4'h0;
                r[23:8] = a[23:8] + 16'h1;
            end
            else
                r[27:24] = a[27:24] + 4'h1;
        end
        else
            r[7:0] = a[7:0] + 8'h1;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // task-file registers; a second write to sector count or cylinder low pushes the byte into the previous copy
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            scCur_ff <= 8'h0; scPrev_ff <= 8'h0; sn_ff <= 8'h0; clCur_ff <= 8'h0;
            clPrev_ff <= 8'h0; ch_ff <= 8'h0; dh_ff <= alw_pkg::DH_FIXED; cmd_ff <= 8'h0;
        end
        else if (tf.tfWr && state_ff == S_IDLE)
        begin
            unique case (tf.tfAddr)
                alw_pkg::TF_SECT_COUNT:
                begin
                    scPrev_ff <= scCur_ff;
                    scCur_ff <= tf.tfData;
                end
                alw_pkg::TF_SECT_NUM: sn_ff <= tf.tfData;
                alw_pkg::TF_CYL_LOW:
                begin
                    clPrev_ff <= clCur_ff;
                    clCur_ff <= tf.tfData;
                end
                alw_pkg::TF_CYL_HIGH: ch_ff <= tf.tfData;
                alw_pkg::TF_DEV_HEAD: dh_ff <= tf.tfData;
                alw_pkg::TF_COMMAND: cmd_ff <= tf.tfData;
                default: ;
            endcase
        end

    ////////////////////////////////////////////////////////////////////////////
    // command checks
    assign logCount = {1'b0, scPrev_ff, scCur_ff};
    assign logStart = {1'b0, clPrev_ff, clCur_ff};
    assign logEnd = logCount + logStart;
    assign logSel = sn_ff;
    assign multCount = (scCur_ff == 8'h0) ? 17'd256 : {9'h0, scCur_ff};
    assign blkSecs = (multBlock == 8'h0) ? 17'h1 : {9'h0, multBlock};

    always_comb
    begin
        logBad = 1'b1;
        if (logSel < 8'(NUM_LOGS))
            logBad = READ_ONLY_LOGS[logSel[LSW-1:0]]
                  || !logFeatureEn[logSel[LSW-1:0]]
                  || logCount == 17'h0
                  || logEnd > 17'(LOG_SECTORS);
    end

    assign abort = state_ff == S_CHECK && ((cmd_ff == alw_pkg::OP_LOG_WRITE && logBad)
                 || (cmd_ff != alw_pkg::OP_LOG_WRITE && cmd_ff != alw_pkg::OP_BLOCK_WRITE));
    assign accept = tf.dataValid && rdy_ff;
    assign sinkFree = isLog_ff || !wrValid || wrReady;
    assign pop = cnt_ff != 2'h0 && sinkFree;
    assign flush = state_ff != S_IDLE && !isLog_ff && mediaErr;
    assign blockEnd = state_ff == S_DRAIN && cnt_ff == 2'h0 && (isLog_ff || !wrValid);
    assign finish = abort || flush || (blockEnd && secLeft_ff == 17'h0);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_blkLeft = blkLeft_ff;
        unique case (state_ff)
            S_IDLE:
                if (tf.tfWr && tf.tfAddr == alw_pkg::TF_COMMAND)
                    nxt_state = S_CHECK;
            S_CHECK:
                if (abort)
                    nxt_state = S_IDLE;
                else
                begin
                    nxt_state = S_XFER;
                    if (cmd_ff == alw_pkg::OP_LOG_WRITE)
                        nxt_blkLeft = 17'(alw_pkg::SECTOR_WORDS);
                    else
                        nxt_blkLeft = 17'((multCount < blkSecs ? multCount : blkSecs) * 256);
                end
            S_XFER:
                if (flush)
                    nxt_state = S_IDLE;
                else if (accept && blkLeft_ff == 17'h1)
                begin
                    nxt_state = S_DRAIN;
                    nxt_blkLeft = 17'h0;
                end
                else if (accept)
                    nxt_blkLeft = blkLeft_ff - 17'h1;
            S_DRAIN:
                if (finish)
                    nxt_state = S_IDLE;
                else if (blockEnd)
                begin
                    nxt_state = S_XFER;
                    nxt_blkLeft = isLog_ff ? 17'(alw_pkg::SECTOR_WORDS)
                        : 17'((secLeft_ff < blkSecs ? secLeft_ff : blkSecs) * 256);
                end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state_ff <= S_IDLE;
            blkLeft_ff <= 17'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            blkLeft_ff <= nxt_blkLeft;
        end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry word buffer between the data port and the sink
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (flush)
            nxt_cnt = 2'h0;
        else if (accept && !pop)
            nxt_cnt = cnt_ff + 2'h1;
        else if (pop && !accept)
            nxt_cnt = cnt_ff - 2'h1;
    end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            cnt_ff <= 2'h0; wPtr_ff <= 1'b0; rPtr_ff <= 1'b0; rdy_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            if (flush)
            begin
                wPtr_ff <= 1'b0;
                rPtr_ff <= 1'b0;
            end
            else
            begin
                if (accept)
                    wPtr_ff <= ~wPtr_ff;
                if (pop)
                    rPtr_ff <= ~rPtr_ff;
            end
            rdy_ff <= nxt_state == S_XFER && nxt_cnt != 2'h2 && nxt_blkLeft != 17'h0;
        end

    always_ff @(posedge clk)
        if (accept)
            fifo_ff[wPtr_ff] <= tf.dataWord;

    ////////////////////////////////////////////////////////////////////////////
    // sinks: log memory or the media write port
    always_ff @(posedge clk)
    begin
        if (pop && isLog_ff)
            logMem[memPtr_ff] <= fifo_ff[rPtr_ff];
        logRdData <= logMem[logRdAddr];
    end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            wrValid <= 1'b0; wrWord <= 16'h0; wrAddr <= 28'h0;
        end
        else if (flush)
            wrValid <= 1'b0;
        else if (pop && !isLog_ff)
        begin
            wrValid <= 1'b1;
            wrWord <= fifo_ff[rPtr_ff];
            wrAddr <= curAddr_ff;
        end
        else if (wrReady)
            wrValid <= 1'b0;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            isLog_ff <= 1'b0; secLeft_ff <= 17'h0; wordInSec_ff <= 8'h0;
            curAddr_ff <= 28'h0; lastAddr_ff <= 28'h0; memPtr_ff <= '0;
        end
        else if (state_ff == S_CHECK)
        begin
            isLog_ff <= cmd_ff == alw_pkg::OP_LOG_WRITE;
            secLeft_ff <= (cmd_ff == alw_pkg::OP_LOG_WRITE) ? logCount : multCount;
            wordInSec_ff <= 8'h0;
            curAddr_ff <= {dh_ff[3:0], ch_ff, clCur_ff, sn_ff};
            lastAddr_ff <= {dh_ff[3:0], ch_ff, clCur_ff, sn_ff};
            memPtr_ff <= MW'((logSel * LOG_SECTORS + logStart) * 256);
        end
        else if (pop)
        begin
            memPtr_ff <= memPtr_ff + MW'(1);
            wordInSec_ff <= wordInSec_ff + 8'h1;
            if (wordInSec_ff == alw_pkg::LAST_WORD)
            begin
                secLeft_ff <= secLeft_ff - 17'h1;
                lastAddr_ff <= curAddr_ff;
                curAddr_ff <= alw_next_addr(curAddr_ff, dh_ff[alw_pkg::DH_LBA]);
            end
        end

    ////////////////////////////////////////////////////////////////////////////
    // status, error, interrupt and completion report
    always_comb
    begin
        nxt_error = error_ff;
        if (state_ff == S_CHECK)
            nxt_error = abort ? 8'h1 << alw_pkg::ER_ABT : alw_pkg::ERROR_RESET;
        else if (flush)
            nxt_error = 8'h1 << alw_pkg::ER_UNC;
    end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            error_ff <= alw_pkg::ERROR_RESET;
            status_ff <= alw_pkg::STATUS_RESET;
        end
        else
        begin
            error_ff <= nxt_error;
            status_ff <= 8'h0;
            status_ff[alw_pkg::ST_BSY] <= nxt_state == S_CHECK || nxt_state == S_DRAIN;
            status_ff[alw_pkg::ST_RDY] <= 1'b1;
            status_ff[alw_pkg::ST_DSC] <= 1'b1;
            status_ff[alw_pkg::ST_DRQ] <= nxt_state == S_XFER;
            status_ff[alw_pkg::ST_ERR] <= nxt_error != 8'h0;
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
            intrq_ff <= 1'b0;
        else if (finish || blockEnd)
            intrq_ff <= 1'b1;
        else if (tf.intAck || (tf.tfWr && tf.tfAddr == alw_pkg::TF_COMMAND))
            intrq_ff <= 1'b0;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            oSc_ff <= 8'h0; oSn_ff <= 8'h0; oCl_ff <= 8'h0; oCh_ff <= 8'h0; oHead_ff <= 4'h0;
        end
        else if (finish && !isLog_ff && state_ff != S_CHECK)
        begin
            oSc_ff <= secLeft_ff[7:0];
            oSn_ff <= lastAddr_ff[7:0];
            oCl_ff <= lastAddr_ff[15:8];
            oCh_ff <= lastAddr_ff[23:16];
            oHead_ff <= lastAddr_ff[27:24];
        end
endmodule // alw_device

/* hw/alw_host.sv */
`timescale 1ns/10ps
module alw_host (
    input wire logic clk,
    input wire logic rst,
    alw_tf_if.host tf,
    input wire logic cmdStart,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdCount,
    input wire logic [27:0] cmdAddr,
    input wire logic cmdLbaMode,
    input wire logic [7:0] cmdLog,
    input wire logic [15:0] cmdLogStart,
    input wire logic srcValid,
    input wire logic [15:0] srcWord,
    output logic srcReady,
    output logic hostBusy,
    output logic doneStrobe,
    output logic [7:0] doneStatus,
    output logic [7:0] doneError,
    output logic [7:0] doneRemain,
    output logic [27:0] doneAddr
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN} alw_hstate_t;

    alw_hstate_t state_ff;
    logic [2:0] idx_ff;
    logic [7:0] code_ff, lobyte, hibyte;
    logic [15:0] count_ff;
    logic [27:0] addr_ff;
    logic lba_ff, isLog;
    logic [24:0] wordsLeft_ff;
    logic hValid_ff, nxt_hValid, take, sent, ack_ff, wr_ff;
    logic [2:0] wAddr_ff;
    logic [7:0] wData_ff, regByte;
    logic [2:0] regAddr;

    assign isLog = code_ff == alw_pkg::OP_LOG_WRITE;
    assign tf.tfWr = wr_ff;
    assign tf.tfAddr = wAddr_ff;
    assign tf.tfData = wData_ff;
    assign tf.intAck = ack_ff;
    assign tf.dataValid = hValid_ff;

    // register writes in order: count high then low, start high then low
    always_comb
    begin
        lobyte = isLog ? cmdLogStart[7:0] : addr_ff[15:8];
        hibyte = isLog ? cmdLogStart[15:8] : 8'h0;
        regAddr = alw_pkg::TF_COMMAND;
        regByte = code_ff;
        unique case (idx_ff)
            3'h0: begin regAddr = alw_pkg::TF_SECT_COUNT; regByte = count_ff[15:8]; end
            3'h1: begin regAddr = alw_pkg::TF_SECT_COUNT; regByte = count_ff[7:0]; end
            3'h2: begin regAddr = alw_pkg::TF_SECT_NUM; regByte = isLog ? cmdLog : addr_ff[7:0]; end
            3'h3: begin regAddr = alw_pkg::TF_CYL_LOW; regByte = hibyte; end
            3'h4: begin regAddr = alw_pkg::TF_CYL_LOW; regByte = lobyte; end
            3'h5: begin regAddr = alw_pkg::TF_CYL_HIGH; regByte = addr_ff[23:16]; end
            3'h6:
            begin
                regAddr = alw_pkg::TF_DEV_HEAD;
                regByte = alw_pkg::DH_FIXED | {1'b0, lba_ff, 2'b0, addr_ff[27:24]};
            end
            default: ;
        endcase
    end

    assign sent = hValid_ff && tf.dataReady;
    assign take = srcValid && srcReady;
    assign nxt_hValid = (hValid_ff && !sent) || take;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state_ff <= H_IDLE; idx_ff <= 3'h0; code_ff <= 8'h0; count_ff <= 16'h0;
            addr_ff <= 28'h0; lba_ff <= 1'b0; wordsLeft_ff <= 25'h0;
            wr_ff <= 1'b0; wAddr_ff <= 3'h0; wData_ff <= 8'h0; hostBusy <= 1'b0;
        end
        else
        begin
            wr_ff <= 1'b0;
            unique case (state_ff)
                H_IDLE:
                    if (cmdStart)
                    begin
                        state_ff <= H_SETUP;
                        hostBusy <= 1'b1;
                        idx_ff <= 3'h0;
                        code_ff <= cmdCode;
                        count_ff <= cmdCount;
                        addr_ff <= cmdAddr;
                        lba_ff <= cmdLbaMode;
                        if (cmdCode == alw_pkg::OP_BLOCK_WRITE)
                            wordsLeft_ff <= (cmdCount[7:0] == 8'h0) ? 25'h10000
                                : {9'h0, cmdCount[7:0], 8'h0};
                        else
                            wordsLeft_ff <= {1'b0, cmdCount, 8'h0};
                    end
                H_SETUP:
                begin
                    wr_ff <= 1'b1;
                    wAddr_ff <= regAddr;
                    wData_ff <= regByte;
                    idx_ff <= idx_ff + 3'h1;
                    if (idx_ff == 3'h7)
                        state_ff <= H_RUN;
                end
                H_RUN:
                begin
                    if (take)
                        wordsLeft_ff <= wordsLeft_ff - 25'h1;
                    if (tf.intrq && !ack_ff && !tf.statusFlags[alw_pkg::ST_BSY]
                        && !tf.statusFlags[alw_pkg::ST_DRQ])
                    begin
                        state_ff <= H_IDLE;
                        hostBusy <= 1'b0;
                    end
                end
                default: ;
            endcase
        end

    ////////////////////////////////////////////////////////////////////////////
    // data hold stage; refills only when empty and while words remain
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            hValid_ff <= 1'b0; tf.dataWord <= 16'h0; srcReady <= 1'b0; ack_ff <= 1'b0;
        end
        else
        begin
            hValid_ff <= nxt_hValid && state_ff == H_RUN && hostBusy;
            if (take)
                tf.dataWord <= srcWord;
            srcReady <= state_ff == H_RUN && tf.statusFlags[alw_pkg::ST_DRQ] && !nxt_hValid
                && wordsLeft_ff > (take ? 25'h1 : 25'h0);
            ack_ff <= tf.intrq && !ack_ff;
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            doneStrobe <= 1'b0; doneStatus <= 8'h0; doneError <= 8'h0;
            doneRemain <= 8'h0; doneAddr <= 28'h0;
        end
        else
        begin
            doneStrobe <= 1'b0;
            if (state_ff == H_RUN && tf.intrq && !ack_ff && !tf.statusFlags[alw_pkg::ST_BSY]
                && !tf.statusFlags[alw_pkg::ST_DRQ])
            begin
                doneStrobe <= 1'b1;
                doneStatus <= tf.statusFlags;
                doneError <= tf.errorFlags;
                doneRemain <= tf.outSectCount;
                doneAddr <= {tf.outHead, tf.outCylHigh, tf.outCylLow, tf.outSectNum};
            end
        end
endmodule // alw_host

/* sim/alw_tf_chk.sv */
`timescale 1ns/10ps
module alw_tf_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic tfWr,
    input wire logic [2:0] tfAddr,
    input wire logic intAck,
    input wire logic dataValid,
    input wire logic [15:0] dataWord,
    input wire logic dataReady,
    input wire logic intrq,
    input wire logic [7:0] statusFlags,
    input wire logic [7:0] errorFlags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_cmd;
        tfWr && tfAddr == alw_pkg::TF_COMMAND;
    endsequence
    sequence s_idle;
        !statusFlags[alw_pkg::ST_BSY] && !statusFlags[alw_pkg::ST_DRQ];
    endsequence
    property p_busy;
        s_cmd ##0 s_idle |-> ##[1:2] statusFlags[alw_pkg::ST_BSY];
    endproperty
    a_busy: assert property (p_busy) else $error("command write did not raise busy");
    property p_cmd_idle;
        s_cmd |-> s_idle;
    endproperty
    a_cmd_idle: assert property (p_cmd_idle) else $error("command issued while busy");
    property p_abort;
        $rose(errorFlags[alw_pkg::ER_ABT]) |->
            statusFlags[alw_pkg::ST_ERR] && intrq && !statusFlags[alw_pkg::ST_BSY];
    endproperty
    a_abort: assert property (p_abort) else $error("abort without error flag or intrq");
    property p_err_code;
        intrq && statusFlags[alw_pkg::ST_ERR] |-> errorFlags != 8'h00;
    endproperty
    a_err_code: assert property (p_err_code) else $error("error set with empty code");
    property p_ready;
        dataReady |-> statusFlags[alw_pkg::ST_DRQ] && !statusFlags[alw_pkg::ST_BSY];
    endproperty
    a_ready: assert property (p_ready) else $error("data ready outside data phase");
    property p_hold;
        dataValid && !dataReady |=> $stable(dataWord) && dataValid;
    endproperty
    a_hold: assert property (p_hold) else $error("data word dropped before taken");
    property p_int_idle;
        $rose(intrq) |-> !statusFlags[alw_pkg::ST_BSY];
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("interrupt while busy");
    property p_ack;
        $rose(intrq) |-> ##[1:2] intAck;
    endproperty
    a_ack: assert property (p_ack) else $error("interrupt not acknowledged");
endmodule // alw_tf_chk

/* sim/test_ata_log_and_multiple_write.sv */
`timescale 1ns/10ps
module test_ata_log_and_multiple_write;
    logic clk;
    logic rst;
    logic cmdStart;
    logic [7:0] cmdCode;
    logic [15:0] cmdCount;
    logic [27:0] cmdAddr;
    logic [7:0] cmdLog;
    logic [15:0] cmdLogStart;
    logic [15:0] srcWord;
    logic srcReady;
    logic doneStrobe;
    logic [7:0] doneStatus;
    logic [7:0] doneError;
    logic wrValid;
    logic wrReady;
    logic [15:0] wrWord;
    logic [27:0] wrAddr;
    logic [27:0] lastWr;
    logic lbaMode;
    logic hostBusy;
    logic [7:0] doneRemain;
    logic [27:0] doneAddr;
    logic [10:0] logRdAddr;
    logic [15:0] logRdData;
    logic [15:0] firstWord;
    logic [15:0] q[$];
    int err_total;
    int num_checks;
    int cyc;
    alw_tf_if tf();
    alw_device i_alw_device (
        .clk(clk), .rst(rst), .tf(tf), .logFeatureEn(4'hb), .multBlock(8'h02), .mediaErr(1'b0),
        .wrValid(wrValid), .wrWord(wrWord), .wrAddr(wrAddr), .wrReady(wrReady),
        .logRdAddr(logRdAddr), .logRdData(logRdData)
    );
    alw_host i_alw_host (
        .clk(clk), .rst(rst), .tf(tf), .cmdStart(cmdStart), .cmdCode(cmdCode),
        .cmdCount(cmdCount), .cmdAddr(cmdAddr), .cmdLbaMode(lbaMode), .cmdLog(cmdLog),
        .cmdLogStart(cmdLogStart), .srcValid(1'b1), .srcWord(srcWord), .srcReady(srcReady),
        .hostBusy(hostBusy), .doneStrobe(doneStrobe), .doneStatus(doneStatus),
        .doneError(doneError), .doneRemain(doneRemain), .doneAddr(doneAddr)
    );
    alw_tf_chk i_alw_tf_chk (
        .clk(clk), .rst(rst), .tfWr(tf.tfWr), .tfAddr(tf.tfAddr), .intAck(tf.intAck),
        .dataValid(tf.dataValid), .dataWord(tf.dataWord), .dataReady(tf.dataReady),
        .intrq(tf.intrq), .statusFlags(tf.statusFlags), .errorFlags(tf.errorFlags)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic run(input logic [7:0] code, input logic [15:0] cnt, input logic [7:0] lg,
                       input logic [15:0] st, input logic [27:0] ad, input logic ab);
        int n;
        n = 0;
        @(posedge clk);
        firstWord = srcWord;
        cmdCode <= code;
        cmdCount <= cnt;
        cmdLog <= lg;
        cmdLogStart <= st;
        cmdAddr <= ad;
        cmdStart <= 1'b1;
        @(posedge clk);
        cmdStart <= 1'b0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (doneStrobe !== 1'b1 && n < 20000);
        check({doneStatus[alw_pkg::ST_ERR], doneError[alw_pkg::ER_ABT]}, {ab, ab});
        check(doneStrobe, 1'b1);
        check(hostBusy, 1'b0);
    endtask
    task automatic peek(input logic [10:0] a, input logic [15:0] e);
        @(posedge clk);
        logRdAddr <= a;
        repeat (2) @(posedge clk);
        #1;
        check(logRdData, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // source counts up per accepted word; sink stalls one cycle in four
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        wrReady <= cyc[0] | cyc[2];
        if (srcReady)
            srcWord <= srcWord + 16'h0001;
        if (srcReady && cmdCode == alw_pkg::OP_BLOCK_WRITE)
            q.push_back(srcWord);
        if (wrValid && wrReady)
        begin
            check(wrWord, q.pop_front());
            lastWr <= wrAddr;
        end
        if (cyc == 30000)
        begin
            err_total++;
            close_out;
        end
    end
    initial
    begin
        rst = 1'b1;
        cyc = 0;
        err_total = 0;
        num_checks = 0;
        cmdStart = 1'b0;
        cmdCode = 8'h00;
        cmdCount = 16'h0000;
        cmdAddr = 28'h0000000;
        cmdLog = 8'h00;
        cmdLogStart = 16'h0000;
        srcWord = 16'h1000;
        wrReady = 1'b1;
        lbaMode = 1'b1;
        lastWr = 28'h0000000;
        logRdAddr = 11'h000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        run(alw_pkg::OP_LOG_WRITE, 16'h0002, 8'h01, 16'h0000, 28'h0, 1'b0);
        peek(11'h200, firstWord);
        peek(11'h3ff, firstWord + 16'h01ff);
        run(alw_pkg::OP_LOG_WRITE, 16'h0001, 8'h01, 16'h0001, 28'h0, 1'b0);
        peek(11'h300, firstWord);
        run(alw_pkg::OP_LOG_WRITE, 16'h0002, 8'h01, 16'h0001, 28'h0, 1'b1);
        run(alw_pkg::OP_LOG_WRITE, 16'h0101, 8'h01, 16'h0000, 28'h0, 1'b1);
        run(alw_pkg::OP_LOG_WRITE, 16'h0001, 8'h01, 16'h0100, 28'h0, 1'b1);
        run(alw_pkg::OP_LOG_WRITE, 16'h0001, 8'h00, 16'h0000, 28'h0, 1'b1);
        run(alw_pkg::OP_LOG_WRITE, 16'h0001, 8'h02, 16'h0000, 28'h0, 1'b1);
        run(alw_pkg::OP_LOG_WRITE, 16'h0000, 8'h01, 16'h0000, 28'h0, 1'b1);
        run(8'h20, 16'h0001, 8'h01, 16'h0000, 28'h0, 1'b1);
        run(alw_pkg::OP_BLOCK_WRITE, 16'h0003, 8'h00, 16'h0000, 28'h12345fe, 1'b0);
        check({tf.outHead, tf.outCylHigh, tf.outCylLow, tf.outSectNum}, 28'h1234600);
        check(tf.outSectCount, 8'h00);
        check(lastWr, 28'h1234600);
        // geometry wrap: last sector of the last head moves to the next cylinder
        @(posedge clk);
        lbaMode <= 1'b0;
        run(alw_pkg::OP_BLOCK_WRITE, 16'h0002, 8'h00, 16'h0000, 28'hf00123f, 1'b0);
        check(doneAddr, 28'h0001301);
        check(lastWr, 28'h0001301);
        check(doneRemain, 8'h00);
        close_out;
    end
endmodule // test_ata_log_and_multiple_write
